// ### core/bccp_pkg.sv
// constants and carrier types of the bar code and cut command parser
package bccp_pkg;
  // command bytes
  localparam logic [7:0] GS = 8'h1d;
  localparam logic [7:0] CMD_POS = 8'h48;
  localparam logic [7:0] CMD_MARGIN = 8'h4c;
  localparam logic [7:0] CMD_LINE = 8'h54;
  localparam logic [7:0] CMD_CUT = 8'h56;
  localparam logic [7:0] CMD_FONT = 8'h66;
  localparam logic [7:0] CMD_HEIGHT = 8'h68;
  localparam logic [7:0] CMD_CODE = 8'h6b;
  // parameter values
  localparam logic [7:0] POS_NONE = 8'h00;
  localparam logic [7:0] POS_BELOW = 8'h02;
  localparam logic [7:0] CUT_NOW = 8'h01;
  localparam logic [7:0] CUT_FEED = 8'h42;
  localparam logic [7:0] SYM_EAN13 = 8'h43;
  localparam logic [7:0] SYM_CODE39 = 8'h45;
  localparam logic [7:0] SYM_ITF = 8'h46;
  localparam logic [7:0] SYM_C128 = 8'h49;
  localparam logic [7:0] EAN_LEN_MIN = 8'h0c;
  localparam logic [7:0] EAN_LEN_MAX = 8'h0d;
  localparam logic [7:0] C128_LEN_MIN = 8'h02;
  localparam logic [7:0] LEN_MIN = 8'h01;
  // code 128 escape pairs
  localparam logic [7:0] ESC = 8'h7b;
  localparam logic [7:0] ESC_SHIFT = 8'h53;
  localparam logic [7:0] ESC_SET_A = 8'h41;
  localparam logic [7:0] ESC_SET_B = 8'h42;
  localparam logic [7:0] ESC_SET_C = 8'h43;
  localparam logic [7:0] ESC_FUNCTION_CODE_ONE = 8'h31;
  localparam logic [7:0] ESC_FNC4 = 8'h34;
  localparam logic [7:0] SET_A_MAX = 8'h5f;
  localparam logic [7:0] SET_B_MIN = 8'h20;
  localparam logic [7:0] SET_C_MAX = 8'h63;
  localparam logic [7:0] CTRL_TOP = 8'h1f;
  localparam logic [7:0] DEL_CHAR = 8'h7f;
  localparam logic [7:0] SPACE = 8'h20;
  // reset values
  localparam logic [7:0] RST_POS = POS_BELOW;
  localparam logic RST_FONT = 1'b1;
  localparam logic [7:0] RST_HEIGHT = 8'ha2;
  localparam logic [15:0] RST_MARGIN = 16'h0000;
  // cutter offset in eighths of a millimetre
  localparam int CUTTER_MM = 16;
  localparam int EIGHTHS_PER_MM = 8;
  localparam logic [9:0] CUTTER_EIGHTHS = 10'(CUTTER_MM * EIGHTHS_PER_MM);
  // speed levels and their maxima in mm/s
  localparam logic [1:0] SPEED_FASTEST = 2'h0;
  localparam logic [7:0] MAX_SPEED1 = 8'd150;
  localparam logic [7:0] MAX_SPEED1_SPLIT = 8'd100;
  localparam logic [7:0] MAX_SPEED2 = 8'd100;
  localparam logic [7:0] MAX_SPEED3 = 8'd80;
  localparam logic [7:0] MAX_SPEED4 = 8'd50;
  // register byte offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MARK = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0c;
  localparam logic [7:0] REG_MARGIN = 8'h10;
  localparam int CTRL_TWO_PART = 2;
  localparam int CTRL_MARK_EN = 3;

  typedef enum logic [3:0] {
    ST_IDLE, ST_GS, ST_PARAM, ST_MLO, ST_MHI, ST_CUTN,
    ST_CODE_M, ST_CODE_N, ST_DATA, ST_ESC
  } bccp_state_t;
  typedef enum logic [2:0] {
    K_DATA, K_SHIFT, K_SET_A, K_SET_B, K_SET_C, K_FUNC
  } bccp_kind_t;
  typedef enum logic [1:0] {SET_A, SET_B, SET_C} bccp_set_t;

  typedef struct packed {
    logic valid;
    logic gs;
    logic [7:0] data;
  } bccp_pass_t;
  typedef struct packed {
    logic valid;
    logic print;
  } bccp_line_t;
  typedef struct packed {
    logic valid;
    logic to_mark;
    logic [9:0] feed;
    logic [15:0] adjust;
    logic feed_back;
  } bccp_cut_t;
  typedef struct packed {
    logic valid;
    logic [7:0] symb;
    logic [7:0] count;
  } bccp_start_t;
  typedef struct packed {
    logic valid;
    bccp_kind_t kind;
    logic [7:0] value;
    logic text_valid;
    logic [7:0] text;
  } bccp_sym_t;
  typedef struct packed {
    logic valid;
    logic abort;
    logic feed_only;
    logic line_return;
  } bccp_end_t;
  typedef struct packed {
    bccp_state_t st;
    logic [7:0] cmd;
    logic [7:0] m;
    logic [7:0] cnt;
    logic odd;
    logic bad;
    logic first;
    bccp_set_t set;
    logic shift;
    logic [7:0] mlo;
    logic [1:0] speed;
    logic two_req;
    logic mark_en;
    logic [15:0] mark_adj;
    logic two_eff;
    logic [7:0] speed_max;
    logic [7:0] pos;
    logic font;
    logic [7:0] height;
    logic [15:0] margin;
    logic [31:0] prdata;
    bccp_pass_t pass;
    bccp_line_t line;
    bccp_cut_t cut;
    bccp_start_t start;
    bccp_sym_t sym;
    bccp_end_t fin;
  } bccp_regs_t;

  localparam bccp_regs_t BCCP_RST = '{
    st: ST_IDLE, set: SET_A, pos: RST_POS, font: RST_FONT,
    height: RST_HEIGHT, margin: RST_MARGIN, speed_max: MAX_SPEED1,
    sym: '{kind: K_DATA, default: '0}, default: '0};
endpackage

// ### core/bccp_parser.sv
// bar code, cut and layout command parser with apb control registers
// Notes on behaviour
// - fastest speed forces single-part energizing
// - two-part energizing caps fastest speed lower; the code never splits at fastest speed, so it keeps MAX_SPEED1
// - text position: none or below, reset below
// - margin is sixteen-bit count of eighths
// - margin changes only at line start
// - line start: discard or print buffer
// - cut mode one cuts immediately, only at line start
// - feed cutter offset plus n, then cut
// - cut only at line start, feed back
// - mark cut: mark plus adjust, then start
// - text font large or small, reset small
// - bar code height one to 255
// - symbology select then n data bytes
// - bad length abandons, rest ordinary data
// - bad data character: feed paper only
// - too wide code: feed paper only
// - bar code only with empty buffer
// - after code return to line start
// - odd itf count drops last byte
// - code 128 escape pairs, leading selector
// - bad escape or character aborts command
// - no text for sets, space for controls
//
// Register access over APB and the address map are this design's own decisions.
module bccp_parser
  import bccp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host byte stream
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // print engine status
  input wire logic at_line_start,
  input wire logic buf_empty,
  input wire logic code_too_wide,
  input wire logic mech_busy,
  // actions towards the print engine
  output bccp_pass_t pass,
  output bccp_line_t line_cmd,
  output bccp_cut_t cut,
  output bccp_start_t code_start,
  output bccp_sym_t sym,
  output bccp_end_t code_end,
  // current settings
  output logic [7:0] text_pos,
  output logic text_font,
  output logic [7:0] code_height,
  output logic [15:0] margin,
  output logic two_part_eff,
  output logic [7:0] speed_max
);
  timeunit 1ns;
  timeprecision 1ns;

  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  bccp_regs_t r;
  bccp_regs_t next_r;

  function automatic logic digit_ok(input logic [7:0] d);
    return d >= 8'h30 && d <= 8'h39;
  endfunction

  function automatic logic c39_ok(input logic [7:0] d);
    return digit_ok(d) || (d >= 8'h41 && d <= 8'h5a) ||
      d == 8'h20 || d == 8'h24 || d == 8'h25 || d == 8'h2b ||
      (d >= 8'h2d && d <= 8'h2f);
  endfunction

  function automatic logic c128_ok(input bccp_set_t s, input logic [7:0] d);
    logic ok;
    ok = 1'b0;
    unique case (s)
      SET_A: ok = d <= SET_A_MAX;
      SET_B: ok = d >= SET_B_MIN && d <= DEL_CHAR;
      SET_C: ok = d <= SET_C_MAX;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic bccp_sym_t emit(input bccp_kind_t k,
      input logic [7:0] v, input logic tv, input logic [7:0] tx);
    bccp_sym_t s;
    s.valid = 1'b1;
    s.kind = k;
    s.value = v;
    s.text_valid = tv;
    s.text = tx;
    return s;
  endfunction

  logic acc;
  logic hit;
  assign acc = psel && penable;
  assign pready = 1'b1;
  assign in_ready = !mech_busy;

  always_comb begin
    logic take;
    logic [7:0] d;
    logic last;
    logic abort;
    logic done;
    logic show;
    logic len_ok;
    bccp_set_t es;
    take = in_valid && in_ready;
    d = in_data;
    last = r.cnt == 8'h01;
    abort = 1'b0;
    done = 1'b0;
    show = r.pos == POS_BELOW;
    len_ok = 1'b0;
    es = r.set;
    hit = 1'b1;
    next_r = r;
    next_r.pass.valid = 1'b0;
    next_r.line.valid = 1'b0;
    next_r.cut.valid = 1'b0;
    next_r.start.valid = 1'b0;
    next_r.sym.valid = 1'b0;
    next_r.fin.valid = 1'b0;

    // register decode, read data caught in the setup cycle
    unique case (paddr[7:0])
      REG_CTRL: next_r.prdata = {28'h0, r.mark_en, r.two_req, r.speed};
      REG_MARK: next_r.prdata = {16'h0, r.mark_adj};
      REG_STAT: next_r.prdata = {16'h0, r.speed_max, 7'h0, r.two_eff};
      REG_CFG: next_r.prdata = {8'h0, r.height, 7'h0, r.font, r.pos};
      REG_MARGIN: next_r.prdata = {16'h0, r.margin};
      default: begin
        next_r.prdata = 32'h0;
        hit = 1'b0;
      end
    endcase
    if (paddr[ADDR_W-1:0] != ADDR_W'(paddr[7:0]) ||
        paddr[1:0] != 2'b00) begin
      hit = 1'b0;
      next_r.prdata = 32'h0;
    end
    if (psel && penable) begin
      next_r.prdata = r.prdata;
    end
    if (acc && pwrite && hit) begin
      if (paddr[7:0] == REG_CTRL) begin
        next_r.speed = pwdata[1:0];
        next_r.two_req = pwdata[CTRL_TWO_PART];
        next_r.mark_en = pwdata[CTRL_MARK_EN];
      end else if (paddr[7:0] == REG_MARK) begin
        next_r.mark_adj = pwdata[15:0];
      end
    end

    // speed level and head energizing
    next_r.two_eff = next_r.two_req && next_r.speed != SPEED_FASTEST;
    unique case (next_r.speed)
      2'h0: next_r.speed_max = next_r.two_eff ?
        MAX_SPEED1_SPLIT : MAX_SPEED1;
      2'h1: next_r.speed_max = MAX_SPEED2;
      2'h2: next_r.speed_max = MAX_SPEED3;
      default: next_r.speed_max = MAX_SPEED4;
    endcase

    // command byte stream
    if (take) begin
      unique case (r.st)
        ST_IDLE: begin
          if (d == GS) begin
            next_r.st = ST_GS;
          end else begin
            next_r.pass = '{valid: 1'b1, gs: 1'b0, data: d};
          end
        end
        ST_GS: begin
          next_r.cmd = d;
          next_r.st = ST_PARAM;
          if (d == CMD_MARGIN) begin
            next_r.st = ST_MLO;
          end else if (d == CMD_CODE) begin
            next_r.st = ST_CODE_M;
          end else if (d != CMD_POS && d != CMD_LINE && d != CMD_CUT &&
              d != CMD_FONT && d != CMD_HEIGHT) begin
            next_r.st = ST_IDLE;
            next_r.pass = '{valid: 1'b1, gs: 1'b1, data: d};
          end
        end
        ST_PARAM: begin
          next_r.st = ST_IDLE;
          if (r.cmd == CMD_POS && (d == POS_NONE || d == POS_BELOW)) begin
            next_r.pos = d;
          end else if (r.cmd == CMD_FONT && d <= 8'h01) begin
            next_r.font = d[0];
          end else if (r.cmd == CMD_HEIGHT && d != 8'h00) begin
            next_r.height = d;
          end else if (r.cmd == CMD_LINE && d <= 8'h01) begin
            next_r.line = '{valid: 1'b1, print: d[0]};
          end else if (r.cmd == CMD_CUT && d == CUT_NOW) begin
            next_r.cut = '{valid: at_line_start, to_mark: 1'b0,
              feed: 10'h0, adjust: 16'h0, feed_back: 1'b1};
          end else if (r.cmd == CMD_CUT && d == CUT_FEED) begin
            next_r.st = ST_CUTN;
          end
        end
        ST_MLO: begin
          next_r.mlo = d;
          next_r.st = ST_MHI;
        end
        ST_MHI: begin
          next_r.st = ST_IDLE;
          if (at_line_start) begin
            next_r.margin = {d, r.mlo};
          end
        end
        ST_CUTN: begin
          next_r.st = ST_IDLE;
          next_r.cut.valid = at_line_start;
          next_r.cut.feed_back = 1'b1;
          next_r.cut.to_mark = r.mark_en;
          if (r.mark_en) begin
            next_r.cut.feed = 10'h0;
            next_r.cut.adjust = r.mark_adj;
          end else begin
            next_r.cut.feed = CUTTER_EIGHTHS + {2'b00, d};
            next_r.cut.adjust = 16'h0;
          end
        end
        ST_CODE_M: begin
          next_r.m = d;
          next_r.st = ST_IDLE;
          if (buf_empty && (d == SYM_EAN13 || d == SYM_CODE39 ||
              d == SYM_ITF || d == SYM_C128)) begin
            next_r.st = ST_CODE_N;
          end
        end
        ST_CODE_N: begin
          next_r.cnt = d;
          next_r.odd = d[0];
          next_r.bad = 1'b0;
          next_r.first = 1'b1;
          next_r.shift = 1'b0;
          next_r.set = SET_A;
          if (r.m == SYM_EAN13) begin
            len_ok = d >= EAN_LEN_MIN && d <= EAN_LEN_MAX;
          end else if (r.m == SYM_C128) begin
            len_ok = d >= C128_LEN_MIN;
          end else begin
            len_ok = d >= LEN_MIN;
          end
          next_r.st = len_ok ? ST_DATA : ST_IDLE;
          next_r.start = '{valid: len_ok, symb: r.m, count: d};
        end
        ST_DATA: begin
          next_r.cnt = r.cnt - 8'h01;
          done = last;
          if (r.m == SYM_C128) begin
            es = r.set;
            if (r.shift) begin
              es = r.set == SET_A ? SET_B : SET_A;
            end
            if (r.first && d != ESC) begin
              abort = 1'b1;
            end else if (d == ESC) begin
              next_r.st = ST_ESC;
              abort = last;
              done = 1'b0;
            end else if (!c128_ok(es, d)) begin
              abort = 1'b1;
            end else begin
              next_r.shift = 1'b0;
              next_r.sym = emit(K_DATA, d, show, (es != SET_C &&
                (d <= CTRL_TOP || d == DEL_CHAR)) ? SPACE : d);
            end
          end else begin
            if ((r.m == SYM_CODE39) ? !c39_ok(d) : !digit_ok(d)) begin
              next_r.bad = 1'b1;
            end
            if (!(r.m == SYM_ITF && last && r.odd)) begin
              next_r.sym = emit(K_DATA, d, show, d);
            end
          end
        end
        ST_ESC: begin
          next_r.cnt = r.cnt - 8'h01;
          next_r.st = ST_DATA;
          next_r.first = 1'b0;
          done = last;
          if (d == ESC_SET_A || d == ESC_SET_B || d == ESC_SET_C) begin
            next_r.shift = 1'b0;
            unique case (d)
              ESC_SET_A: begin
                next_r.set = SET_A;
                next_r.sym = emit(K_SET_A, d, 1'b0, SPACE);
              end
              ESC_SET_B: begin
                next_r.set = SET_B;
                next_r.sym = emit(K_SET_B, d, 1'b0, SPACE);
              end
              default: begin
                next_r.set = SET_C;
                next_r.sym = emit(K_SET_C, d, 1'b0, SPACE);
              end
            endcase
          end else if (r.first) begin
            abort = 1'b1;
          end else if (d == ESC_SHIFT && r.set != SET_C) begin
            next_r.shift = 1'b1;
            next_r.sym = emit(K_SHIFT, d, 1'b0, SPACE);
          end else if (d >= ESC_FUNCTION_CODE_ONE && d <= ESC_FNC4) begin
            next_r.sym = emit(K_FUNC, d - 8'h30, show, SPACE);
          end else if (d == ESC && r.set == SET_B && !r.shift) begin
            next_r.sym = emit(K_DATA, ESC, show, ESC);
          end else begin
            abort = 1'b1;
          end
        end
        default: next_r.st = ST_IDLE;
      endcase
      if (abort) begin
        next_r.st = ST_IDLE;
        next_r.sym.valid = 1'b0;
        next_r.fin = '{valid: 1'b1, abort: 1'b1, feed_only: 1'b0,
          line_return: 1'b0};
      end else if (done) begin
        next_r.st = ST_IDLE;
        next_r.fin = '{valid: 1'b1, abort: 1'b0,
          feed_only: next_r.bad || code_too_wide,
          line_return: 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= BCCP_RST;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pslverr = acc && !hit;
  assign pass = r.pass;
  assign line_cmd = r.line;
  assign cut = r.cut;
  assign code_start = r.start;
  assign sym = r.sym;
  assign code_end = r.fin;
  assign text_pos = r.pos;
  assign text_font = r.font;
  assign code_height = r.height;
  assign margin = r.margin;
  assign two_part_eff = r.two_eff;
  assign speed_max = r.speed_max;
endmodule

// ### dv/bccp_parser_assertions.sv
// concurrent checks on the parser ports
module bccp_parser_assertions
  import bccp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // stream and engine status
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_ready,
  input wire logic at_line_start,
  input wire logic buf_empty,
  // actions
  input wire bccp_pass_t pass,
  input wire bccp_cut_t cut,
  input wire bccp_start_t code_start,
  input wire bccp_sym_t sym,
  // settings
  input wire logic [7:0] text_pos,
  input wire logic text_font,
  input wire logic [7:0] code_height,
  input wire logic [15:0] margin,
  input wire logic two_part_eff,
  input wire logic [7:0] speed_max
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_fast_single;
    speed_max == MAX_SPEED1 |-> !two_part_eff;
  endproperty
  a_fast_single: assert property (p_fast_single)
    else $error("split energizing at fastest speed");
  property p_split_cap;
    two_part_eff |-> speed_max <= MAX_SPEED1_SPLIT;
  endproperty
  a_split_cap: assert property (p_split_cap)
    else $error("speed not capped while split");
  property p_pos_set;
    $changed(text_pos) |-> $past(in_valid && in_ready)
      && text_pos == $past(in_data);
  endproperty
  a_pos_set: assert property (p_pos_set)
    else $error("text position changed without its byte");
  property p_margin_start;
    $changed(margin) |-> $past(at_line_start) && $past(in_valid && in_ready)
      && margin[15:8] == $past(in_data);
  endproperty
  a_margin_start: assert property (p_margin_start)
    else $error("margin changed off line start");
  property p_font_hold;
    !$past(in_valid && in_ready) |-> $stable(text_font);
  endproperty
  a_font_hold: assert property (p_font_hold)
    else $error("font changed with no byte");
  property p_height_set;
    $changed(code_height) |-> code_height == $past(in_data)
      && code_height != 8'h00;
  endproperty
  a_height_set: assert property (p_height_set)
    else $error("bad height update");
  property p_cut_feed;
    cut.valid && !cut.to_mark && cut.feed != 10'h000
      |-> cut.feed == CUTTER_EIGHTHS + 10'($past(in_data));
  endproperty
  a_cut_feed: assert property (p_cut_feed)
    else $error("cut feed wrong");
  property p_cut_start;
    cut.valid |-> $past(at_line_start) && cut.feed_back ##1 !cut.valid;
  endproperty
  a_cut_start: assert property (p_cut_start)
    else $error("cut off line start or no feed back");
  property p_code_empty;
    code_start.valid |-> $past(buf_empty);
  endproperty
  a_code_empty: assert property (p_code_empty)
    else $error("bar code started with full buffer");
  property p_pass_taken;
    pass.valid |-> $past(in_valid && in_ready);
  endproperty
  a_pass_taken: assert property (p_pass_taken)
    else $error("pass byte with no byte taken");
  property p_set_notext;
    sym.valid && sym.kind inside {K_SHIFT, K_SET_A, K_SET_B, K_SET_C}
      |-> !sym.text_valid;
  endproperty
  a_set_notext: assert property (p_set_notext)
    else $error("text for set selector");
  property p_func_space;
    sym.valid && sym.text_valid && sym.kind == K_FUNC |-> sym.text == SPACE;
  endproperty
  a_func_space: assert property (p_func_space)
    else $error("function text not space");
endmodule

// ### dv/bccp_host_model.sv
// host model: sends queued bytes, holds each until taken
module bccp_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // byte stream
  input wire logic in_ready,
  input wire logic slow,
  output logic in_valid,
  output logic [7:0] in_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$];
  logic gap = 1'b0;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_valid <= 1'b0;
      in_data <= 8'h00;
    end else if (in_valid && !in_ready) begin
      gap <= gap;
    end else if (q.size() > 0 && !gap) begin
      in_valid <= 1'b1;
      in_data <= q.pop_front();
      gap <= slow;
    end else begin
      in_valid <= 1'b0;
      in_data <= ~in_data;
      gap <= 1'b0;
    end
  end
endmodule

// ### dv/barcode_cut_command_parser_bench.sv
// self-checking bench of the command parser
module barcode_cut_command_parser_bench import bccp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, stall = 0;
  logic at_line_start = 1, buf_empty = 1, code_too_wide = 0, mech_busy = 0;
  logic [7:0] paddr = 0, text_pos, code_height, speed_max, in_data, nb;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, in_valid, in_ready, text_font, two_part_eff, er;
  logic [15:0] margin, madj, mv;
  bccp_pass_t pass;
  bccp_line_t line_cmd;
  bccp_cut_t cut, lcut;
  bccp_start_t code_start, lstart;
  bccp_sym_t sym;
  bccp_end_t code_end, lend;
  int errors = 0, n_compared = 0, seed = 93890, v, hv;
  int ncut, nstart, nend, nsym, spd[4] = '{150, 100, 80, 50};
  logic lprint, lgs;
  logic [7:0] pq[$], tq[$];
  always #10 clk = ~clk;
  always @(posedge clk) mech_busy <= stall & 1'($random(seed));
  bccp_parser bccp_parser_i (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .at_line_start(at_line_start), .buf_empty(buf_empty),
    .code_too_wide(code_too_wide), .mech_busy(mech_busy), .pass(pass),
    .line_cmd(line_cmd), .cut(cut), .code_start(code_start), .sym(sym),
    .code_end(code_end), .text_pos(text_pos), .text_font(text_font),
    .code_height(code_height), .margin(margin),
    .two_part_eff(two_part_eff), .speed_max(speed_max));
  bccp_host_model bccp_host_model_i (.clk(clk), .rst_n(rst_n),
    .in_ready(in_ready), .slow(stall), .in_valid(in_valid),
    .in_data(in_data));
  always @(posedge clk) begin
    if (pass.valid) begin pq.push_back(pass.data); lgs = pass.gs; end
    if (sym.valid) nsym++;
    if (sym.valid && sym.text_valid) tq.push_back(sym.text);
    if (cut.valid) begin ncut++; lcut = cut; end
    if (code_start.valid) begin nstart++; lstart = code_start; end
    if (code_end.valid) begin nend++; lend = code_end; end
    if (line_cmd.valid) lprint = line_cmd.print;
  end
  task chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task report_and_stop;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin errors++; report_and_stop; end
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
  endtask
  task send(input logic [7:0] b[$]);
    int k;
    pq = {}; tq = {}; ncut = 0; nstart = 0; nend = 0; nsym = 0;
    foreach (b[i]) bccp_host_model_i.q.push_back(b[i]);
    k = 0;
    while ((bccp_host_model_i.q.size() > 0 || in_valid) && k < 2000) begin
      @(posedge clk); k++;
    end
    if (k == 2000) begin errors++; report_and_stop; end
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk("pos_rst", 8'h02, text_pos);
    chk("font_rst", 1, text_font);
    chk("height_rst", 162, code_height);
    chk("margin_rst", 0, margin);
    for (v = 0; v < 4; v++) begin
      apb(1, REG_CTRL, 32'(4 + v));
      apb(0, REG_STAT, 0);
      chk("two_part", v != 0, rd[0]);
      chk("speed_max", spd[v], rd[15:8]);
      chk("two_part_pin", v != 0, two_part_eff);
      chk("speed_pin", spd[v], speed_max);
    end
    apb(0, 8'h40, 0);
    chk("slverr", 1, er);
    madj = 16'($random(seed));
    apb(1, REG_MARK, 32'(madj));
    apb(0, REG_MARK, 0);
    chk("mark", madj, rd[15:0]);
    for (v = 0; v < 3; v++) begin
      send('{GS, CMD_POS, 8'(2 - v)});
      chk("text_pos", v == 2 ? 0 : 2, text_pos);
    end
    for (v = 0; v < 2; v++) begin
      send('{GS, CMD_FONT, 8'(v)});
      chk("font", v, text_font);
    end
    hv = 1 + ((($random(seed)) & 32'h7fffffff) % 255);
    send('{GS, CMD_HEIGHT, 8'(hv)});
    send('{GS, CMD_HEIGHT, 8'h00});
    chk("height", hv, code_height);
    send('{GS, 8'h77});
    chk("gs_letter", 8'h77, pq.size() == 1 ? pq[0] : 8'h00);
    chk("gs_flag", 1, lgs);
    stall <= 1;
    mv = 16'($random(seed));
    send('{GS, CMD_MARGIN, mv[7:0], mv[15:8]});
    chk("margin", mv, margin);
    at_line_start <= 0;
    send('{GS, CMD_MARGIN, ~mv[7:0], ~mv[15:8]});
    chk("margin_hold", mv, margin);
    stall <= 0;
    at_line_start <= 1;
    for (v = 0; v < 2; v++) begin
      send('{GS, CMD_LINE, 8'(v)});
      chk("line_print", v, lprint);
    end
    for (v = 0; v < 4; v++) begin
      apb(1, REG_CTRL, v > 1 ? 8 : 0);
      nb = 8'($random(seed));
      if (v[0]) send('{GS, CMD_CUT, CUT_FEED, nb});
      else send('{GS, CMD_CUT, CUT_NOW});
      chk("cuts", 1, ncut);
      chk("to_mark", v == 3, lcut.to_mark);
      chk("feed", v == 1 ? 128 + nb : 0, lcut.feed);
      chk("feed_back", 1, lcut.feed_back);
      if (v == 3) chk("adjust", madj, lcut.adjust);
    end
    at_line_start <= 0;
    send('{GS, CMD_CUT, CUT_NOW});
    chk("cut_off_start", 0, ncut);
    at_line_start <= 1;
    apb(1, REG_CTRL, 0);
    send('{GS, CMD_CODE, SYM_ITF, 8'h03, 8'h31, 8'h32, 8'h33});
    chk("symb", SYM_ITF, lstart.symb);
    chk("count", 3, lstart.count);
    chk("itf_syms", 2, nsym);
    chk("itf_end", 1, nend);
    chk("line_ret", 1, lend.line_return);
    send('{GS, CMD_CODE, SYM_EAN13, 8'h05, 8'h41});
    chk("ean_start", 0, nstart);
    chk("ean_pass", 8'h41, pq.size() == 1 ? pq[0] : 8'h00);
    send('{GS, CMD_CODE, SYM_CODE39, 8'h01, 8'h61});
    chk("bad_char", 1, lend.feed_only);
    code_too_wide <= 1;
    send('{GS, CMD_CODE, SYM_ITF, 8'h02, 8'h31, 8'h32});
    chk("too_wide", 1, lend.feed_only);
    code_too_wide <= 0;
    buf_empty <= 0;
    send('{GS, CMD_CODE, SYM_CODE39, 8'h01, 8'h41});
    chk("full_start", 0, nstart);
    chk("full_pass", 2, pq.size());
    buf_empty <= 1;
    send('{GS, CMD_POS, POS_BELOW});
    send('{GS, CMD_CODE, SYM_C128, 8'h06, ESC, ESC_SET_A, 8'h41, 8'h05,
      ESC, ESC_FUNCTION_CODE_ONE});
    chk("c128_syms", 4, nsym);
    chk("c128_abort", 0, lend.abort);
    chk("c128_text", {8'h41, 8'h20, 8'h20}, {tq[0], tq[1], tq[2]});
    send('{GS, CMD_CODE, SYM_C128, 8'h02, 8'h41, 8'h42});
    chk("no_selector", 1, lend.abort);
    send('{GS, CMD_CODE, SYM_C128, 8'h04, ESC, ESC_SET_B, ESC, 8'h5a});
    chk("bad_escape", 1, lend.abort);
    send('{GS, CMD_CODE, SYM_C128, 8'h0a, ESC, ESC_SET_B, ESC, ESC, ESC,
      ESC_SHIFT, 8'h01, ESC, ESC_SET_C, 8'h63});
    chk("mix_syms", 6, nsym);
    chk("mix_abort", 0, lend.abort);
    chk("mix_text", {8'h7b, 8'h20, 8'h63}, {tq[0], tq[1], tq[2]});
    report_and_stop;
  end
endmodule
bind bccp_parser bccp_parser_assertions bccp_parser_assertions_i (
  .clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data),
  .in_ready(in_ready), .at_line_start(at_line_start),
  .buf_empty(buf_empty), .pass(pass), .cut(cut), .code_start(code_start),
  .sym(sym), .text_pos(text_pos), .text_font(text_font),
  .code_height(code_height), .margin(margin),
  .two_part_eff(two_part_eff), .speed_max(speed_max));
